// ===== core/tlv_pkg.sv
`default_nettype none
package tlv_pkg;
	localparam int unsigned NSRC  = 12;
	localparam int unsigned SIW   = 4;
	localparam int unsigned VW    = 16;
	localparam int unsigned NCORE = 8;
	localparam int unsigned NXP   = 5;
	localparam int unsigned USB_EW = 3;
	localparam int unsigned USB_PW = 8;

	////////////////////////////////////////////////////////////////
	// Source slots in polling order, slot 0 polled first
	localparam logic [SIW-1:0] S_EXT0 = 4'h0;
	localparam logic [SIW-1:0] S_TMR0 = 4'h1;
	localparam logic [SIW-1:0] S_EXT1 = 4'h2;
	localparam logic [SIW-1:0] S_TMR1 = 4'h3;
	localparam logic [SIW-1:0] S_SER  = 4'h4;
	localparam logic [SIW-1:0] S_TMR2 = 4'h5;
	localparam logic [SIW-1:0] S_EXT2 = 4'h6;
	localparam logic [SIW-1:0] S_EXT3 = 4'h7;
	localparam logic [SIW-1:0] S_SPI  = 4'h8;
	localparam logic [SIW-1:0] S_KEY  = 4'h9;
	localparam logic [SIW-1:0] S_TWI  = 4'ha;
	localparam logic [SIW-1:0] S_USB  = 4'hb;

	// Flags held in the unit itself
	localparam int unsigned C_TMR0 = 0;
	localparam int unsigned C_TMR1 = 1;
	localparam int unsigned C_RXD  = 2;
	localparam int unsigned C_TXD  = 3;
	localparam int unsigned C_T2OV = 4;
	localparam int unsigned C_SPI  = 5;
	localparam int unsigned C_KEY  = 6;
	localparam int unsigned C_TWI  = 7;

	// Pin-driven flags
	localparam int unsigned X_EXT0 = 0;
	localparam int unsigned X_EXT1 = 1;
	localparam int unsigned X_EXT2 = 2;
	localparam int unsigned X_EXT3 = 3;
	localparam int unsigned X_TIMER2_EXTERNAL_PIN = 4;

	localparam logic [VW-1:0] VEC_EXT0 = 16'h0003;
	localparam logic [VW-1:0] VEC_TMR0 = 16'h000b;
	localparam logic [VW-1:0] VEC_EXT1 = 16'h0013;
	localparam logic [VW-1:0] VEC_TMR1 = 16'h001b;
	localparam logic [VW-1:0] VEC_SER  = 16'h0023;
	localparam logic [VW-1:0] VEC_TMR2 = 16'h002b;
	localparam logic [VW-1:0] VEC_EXT2 = 16'h0033;
	localparam logic [VW-1:0] VEC_EXT3 = 16'h003b;
	localparam logic [VW-1:0] VEC_SPI  = 16'h0043;
	localparam logic [VW-1:0] VEC_KEY  = 16'h006b;
	localparam logic [VW-1:0] VEC_TWI  = 16'h0073;
	localparam logic [VW-1:0] VEC_USB  = 16'h007b;
	localparam logic [VW-1:0] VEC_NONE = 16'h0000;

	typedef enum logic [1:0] {SVC_IDLE, SVC_LOW, SVC_HIGH, SVC_NEST} tlv_svc_e;

	typedef struct packed {
		logic cycle_valid;
		logic last_cycle;
		logic return_from_interrupt;
		logic irq_reg_write;
	} tlv_cpu_s;

	typedef struct packed {
		logic global_irq_enable;
		logic usb_irq_enable;
		logic two_wire_irq_enable;
		logic keypad_irq_enable;
		logic spi_irq_enable;
		logic ext3_enable;
		logic ext2_enable;
		logic timer2_irq_enable;
		logic serial_irq_enable;
		logic timer1_irq_enable;
		logic ext1_enable;
		logic timer0_irq_enable;
		logic ext0_enable;
	} tlv_en_s;

	typedef struct packed {
		logic ext0_type_select;
		logic ext1_type_select;
		logic ext2_level_edge_select;
		logic ext2_polarity_select;
		logic ext3_level_edge_select;
		logic ext3_polarity_select;
		logic timer2_external_pin_enable;
	} tlv_ext_cfg_s;

	function automatic logic [VW-1:0] tlv_vec_of(input logic [SIW-1:0] idx);
		unique case (idx)
			S_EXT0:  tlv_vec_of = VEC_EXT0;
			S_TMR0:  tlv_vec_of = VEC_TMR0;
			S_EXT1:  tlv_vec_of = VEC_EXT1;
			S_TMR1:  tlv_vec_of = VEC_TMR1;
			S_SER:   tlv_vec_of = VEC_SER;
			S_TMR2:  tlv_vec_of = VEC_TMR2;
			S_EXT2:  tlv_vec_of = VEC_EXT2;
			S_EXT3:  tlv_vec_of = VEC_EXT3;
			S_SPI:   tlv_vec_of = VEC_SPI;
			S_KEY:   tlv_vec_of = VEC_KEY;
			S_TWI:   tlv_vec_of = VEC_TWI;
			S_USB:   tlv_vec_of = VEC_USB;
			default: tlv_vec_of = VEC_NONE;
		endcase
	endfunction : tlv_vec_of
endpackage : tlv_pkg
`default_nettype wire

// ===== core/tlv_ext_flag.sv
`timescale 1ns/1ps
`default_nettype none
module tlv_ext_flag (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic pin,
	input  wire logic arm,
	input  wire logic edge_mode,
	input  wire logic active_high,
	input  wire logic vec_clr,
	input  wire logic fw_wr,
	input  wire logic fw_data,
	output logic      flag
);
	logic meta;
	logic sync;
	logic sync_d;
	logic act;
	logic act_d;
	logic trig_edge;
	logic next_flag;
	logic [2:0] fill;

	////////////////////////////////////////////////////////////////
	// Pin crosses in through two flops; edges compare sync with its delayed copy sync_d
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta   <= 1'h0;
			sync   <= 1'h0;
			sync_d <= 1'h0;
			fill   <= 3'h0;
		end else begin
			meta   <= pin;
			sync   <= meta;
			sync_d <= sync;
			fill   <= {fill[1:0], 1'h1};
		end
	end

	// Reset zeros are not the idle level of an active-low pin; ignore them until the pipe fills
	assign act       = active_high ? sync : ~sync;
	assign act_d     = active_high ? sync_d : ~sync_d;
	assign trig_edge = act & ~act_d & fill[2];

	////////////////////////////////////////////////////////////////
	always_comb begin
		next_flag = flag;
		if (edge_mode) begin
			if (vec_clr) next_flag = 1'h0;
			if (fw_wr) next_flag = fw_data;
			if (arm && trig_edge) next_flag = 1'h1;
		end else begin
			// Level mode: the source owns the flag, a write lasts one cycle
			next_flag = arm & act & fill[1];
			if (fw_wr) next_flag = fw_data;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) flag <= 1'h0;
		else flag <= next_flag;
	end
endmodule : tlv_ext_flag
`default_nettype wire

// ===== core/tlv_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module tlv_arbiter #(
	parameter int unsigned N  = tlv_pkg::NSRC,
	parameter int unsigned IW = tlv_pkg::SIW
) (
	input  wire logic [N-1:0]  req,
	input  wire logic [N-1:0]  prio,
	input  wire logic          hi_busy,
	input  wire logic          lo_busy,
	output logic               hit,
	output logic               hit_high,
	output logic [IW-1:0]      hit_idx
);
	logic [N-1:0] hi_req;
	logic [N-1:0] lo_req;

	function automatic logic [IW-1:0] first_set(input logic [N-1:0] v);
		first_set = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) first_set = IW'(i);
		end
	endfunction : first_set

	assign hi_req = req & prio;
	assign lo_req = req & ~prio;

	always_comb begin
		hit      = 1'h0;
		hit_high = 1'h0;
		hit_idx  = '0;
		if (!hi_busy && |hi_req) begin
			hit      = 1'h1;
			hit_high = 1'h1;
			hit_idx  = first_set(hi_req);
		end else if (!hi_busy && !lo_busy && |lo_req) begin
			hit     = 1'h1;
			hit_idx = first_set(lo_req);
		end
	end
endmodule : tlv_arbiter
`default_nettype wire

// ===== core/tlv_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tlv_unit #(
	parameter int unsigned USB_EW = tlv_pkg::USB_EW,
	parameter int unsigned USB_PW = tlv_pkg::USB_PW
) (
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	input  wire tlv_pkg::tlv_cpu_s             cpu,
	input  wire tlv_pkg::tlv_en_s              en,
	input  wire logic [tlv_pkg::NSRC-1:0]      priority_select,
	input  wire tlv_pkg::tlv_ext_cfg_s         ext_cfg,
	input  wire logic [3:0]                    ext_pin,
	input  wire logic                          timer2_external_pin,
	input  wire logic [tlv_pkg::NCORE-1:0]     core_flag_set,
	input  wire logic [tlv_pkg::NCORE-1:0]     core_flag_wr,
	input  wire logic [tlv_pkg::NCORE-1:0]     core_flag_data,
	input  wire logic [tlv_pkg::NXP-1:0]       ext_flag_wr,
	input  wire logic [tlv_pkg::NXP-1:0]       ext_flag_data,
	input  wire logic [USB_EW-1:0]             usb_event_flags,
	input  wire logic [USB_PW-1:0]             usb_endpoint_flags,
	output logic                               irq_take,
	output logic [tlv_pkg::VW-1:0]             vector_addr,
	output logic [tlv_pkg::SIW-1:0]            taken_idx,
	output logic                               taken_high,
	output logic                               svc_high_active,
	output logic                               svc_low_active,
	output logic [tlv_pkg::NCORE-1:0]          core_flags,
	output logic [tlv_pkg::NXP-1:0]            ext_flags
);
	logic                          rst_meta;
	logic                          rst_n;
	logic [tlv_pkg::NXP-1:0]       xp_pin;
	logic [tlv_pkg::NXP-1:0]       xp_arm;
	logic [tlv_pkg::NXP-1:0]       xp_edge;
	logic [tlv_pkg::NXP-1:0]       xp_high;
	logic [tlv_pkg::NXP-1:0]       xp_clr;
	wire logic [tlv_pkg::NXP-1:0]  xp_flag;
	logic [tlv_pkg::NCORE-1:0]     core_clr;
	logic [tlv_pkg::NCORE-1:0]     next_core_flags;
	logic [tlv_pkg::NSRC-1:0]      req;
	logic [tlv_pkg::NSRC-1:0]      gated;
	logic [tlv_pkg::NSRC-1:0]      sampled;
	logic [tlv_pkg::NSRC-1:0]      next_sampled;
	logic                          hit;
	logic                          hit_high;
	logic [tlv_pkg::SIW-1:0]       hit_idx;
	logic                          hi_busy;
	logic                          lo_busy;
	logic                          take_now;
	tlv_pkg::tlv_svc_e             svc;
	tlv_pkg::tlv_svc_e             next_svc;
	logic                          next_irq_take;
	logic [tlv_pkg::VW-1:0]        next_vector_addr;
	logic [tlv_pkg::SIW-1:0]       next_taken_idx;
	logic                          next_taken_high;

	////////////////////////////////////////////////////////////////
	// Reset release
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'h0;
			rst_n    <= 1'h0;
		end else begin
			rst_meta <= 1'h1;
			rst_n    <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin-driven flags; pins 0 and 1 are active low
	assign xp_pin  = {timer2_external_pin, ext_pin};
	assign xp_arm  = {ext_cfg.timer2_external_pin_enable, 4'hf};
	assign xp_edge = {1'h1, ext_cfg.ext3_level_edge_select,
		ext_cfg.ext2_level_edge_select, ext_cfg.ext1_type_select,
		ext_cfg.ext0_type_select};
	assign xp_high = {1'h0, ext_cfg.ext3_polarity_select,
		ext_cfg.ext2_polarity_select, 2'h0};

	localparam int unsigned X_EXT0 = tlv_pkg::X_EXT0;
	localparam int unsigned X_EXT1 = tlv_pkg::X_EXT1;
	localparam int unsigned X_EXT2 = tlv_pkg::X_EXT2;
	localparam int unsigned X_EXT3 = tlv_pkg::X_EXT3;

	always_comb begin
		xp_clr         = '0;
		xp_clr[X_EXT0] = take_now && hit_idx == tlv_pkg::S_EXT0;
		xp_clr[X_EXT1] = take_now && hit_idx == tlv_pkg::S_EXT1;
		xp_clr[X_EXT2] = take_now && hit_idx == tlv_pkg::S_EXT2;
		xp_clr[X_EXT3] = take_now && hit_idx == tlv_pkg::S_EXT3;
	end

	for (genvar g = 0; g < tlv_pkg::NXP; g++) begin : g_xp
		tlv_ext_flag u_flag (
			.mclk        (mclk),
			.rst_n       (rst_n),
			.pin         (xp_pin[g]),
			.arm         (xp_arm[g]),
			.edge_mode   (xp_edge[g]),
			.active_high (xp_high[g]),
			.vec_clr     (xp_clr[g]),
			.fw_wr       (ext_flag_wr[g]),
			.fw_data     (ext_flag_data[g]),
			.flag        (xp_flag[g])
		);
	end

	assign ext_flags = xp_flag;

	////////////////////////////////////////////////////////////////
	// Held flags; a hardware set beats a clear in the same cycle
	always_comb begin
		core_clr                  = '0;
		core_clr[tlv_pkg::C_TMR0] = take_now && hit_idx == tlv_pkg::S_TMR0;
		core_clr[tlv_pkg::C_TMR1] = take_now && hit_idx == tlv_pkg::S_TMR1;
	end

	always_comb begin
		next_core_flags = core_flags;
		for (int i = 0; i < tlv_pkg::NCORE; i++) begin
			if (core_clr[i]) next_core_flags[i] = 1'h0;
			if (core_flag_wr[i]) next_core_flags[i] = core_flag_data[i];
			if (core_flag_set[i]) next_core_flags[i] = 1'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) core_flags <= '0;
		else core_flags <= next_core_flags;
	end

	////////////////////////////////////////////////////////////////
	// Requests; serial, timer2, keypad, SPI, two-wire and USB never cleared here
	always_comb begin
		req                 = '0;
		req[tlv_pkg::S_EXT0] = ext_flags[X_EXT0];
		req[tlv_pkg::S_TMR0] = core_flags[tlv_pkg::C_TMR0];
		req[tlv_pkg::S_EXT1] = ext_flags[X_EXT1];
		req[tlv_pkg::S_TMR1] = core_flags[tlv_pkg::C_TMR1];
		req[tlv_pkg::S_SER]  = core_flags[tlv_pkg::C_RXD] | core_flags[tlv_pkg::C_TXD];
		req[tlv_pkg::S_TMR2] = core_flags[tlv_pkg::C_T2OV] | ext_flags[tlv_pkg::X_TIMER2_EXTERNAL_PIN];
		req[tlv_pkg::S_EXT2] = ext_flags[X_EXT2];
		req[tlv_pkg::S_EXT3] = ext_flags[X_EXT3];
		req[tlv_pkg::S_SPI]  = core_flags[tlv_pkg::C_SPI];
		req[tlv_pkg::S_KEY]  = core_flags[tlv_pkg::C_KEY];
		req[tlv_pkg::S_TWI]  = core_flags[tlv_pkg::C_TWI];
		req[tlv_pkg::S_USB]  = |usb_event_flags | |usb_endpoint_flags;
	end

	assign gated = req & en[tlv_pkg::NSRC-1:0] & {tlv_pkg::NSRC{en.global_irq_enable}};

	// A level request missed while blocked is not remembered
	assign next_sampled = cpu.cycle_valid ? gated : sampled;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) sampled <= '0;
		else sampled <= next_sampled;
	end

	////////////////////////////////////////////////////////////////
	// Poll and vector
	assign hi_busy = svc == tlv_pkg::SVC_HIGH || svc == tlv_pkg::SVC_NEST;
	assign lo_busy = svc == tlv_pkg::SVC_LOW || svc == tlv_pkg::SVC_NEST;

	tlv_arbiter #(
		.N  (tlv_pkg::NSRC),
		.IW (tlv_pkg::SIW)
	) u_arb (
		.req      (sampled),
		.prio     (priority_select),
		.hi_busy  (hi_busy),
		.lo_busy  (lo_busy),
		.hit      (hit),
		.hit_high (hit_high),
		.hit_idx  (hit_idx)
	);

	assign take_now = hit && cpu.cycle_valid && cpu.last_cycle
		&& !cpu.return_from_interrupt && !cpu.irq_reg_write;

	always_comb begin
		next_svc         = svc;
		next_irq_take    = 1'h0;
		next_vector_addr = vector_addr;
		next_taken_idx   = taken_idx;
		next_taken_high  = taken_high;
		if (take_now) begin
			next_irq_take    = 1'h1;
			next_vector_addr = tlv_pkg::tlv_vec_of(hit_idx);
			next_taken_idx   = hit_idx;
			next_taken_high  = hit_high;
			if (!hit_high) next_svc = tlv_pkg::SVC_LOW;
			else if (svc == tlv_pkg::SVC_LOW) next_svc = tlv_pkg::SVC_NEST;
			else next_svc = tlv_pkg::SVC_HIGH;
		end else if (cpu.cycle_valid && cpu.return_from_interrupt) begin
			unique case (svc)
				tlv_pkg::SVC_NEST: next_svc = tlv_pkg::SVC_LOW;
				tlv_pkg::SVC_HIGH: next_svc = tlv_pkg::SVC_IDLE;
				tlv_pkg::SVC_LOW:  next_svc = tlv_pkg::SVC_IDLE;
				tlv_pkg::SVC_IDLE: next_svc = tlv_pkg::SVC_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			svc         <= tlv_pkg::SVC_IDLE;
			irq_take    <= 1'h0;
			vector_addr <= tlv_pkg::VEC_NONE;
			taken_idx   <= '0;
			taken_high  <= 1'h0;
		end else begin
			svc         <= next_svc;
			irq_take    <= next_irq_take;
			vector_addr <= next_vector_addr;
			taken_idx   <= next_taken_idx;
			taken_high  <= next_taken_high;
		end
	end

	assign svc_high_active = hi_busy;
	assign svc_low_active  = lo_busy;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_poll_ok;
		cpu.cycle_valid && cpu.last_cycle && !cpu.return_from_interrupt && !cpu.irq_reg_write;
	endsequence

	sequence s_global_off;
		(!en.global_irq_enable && cpu.cycle_valid) ##1 !en.global_irq_enable;
	endsequence

	sequence s_return_from_interrupt_high;
		cpu.cycle_valid && cpu.return_from_interrupt && svc == tlv_pkg::SVC_HIGH;
	endsequence

	AST_TAKE_WHEN_FREE: assert property ((s_poll_ok ##0 hit) |=> irq_take)
		else $error("pending request not vectored");

	AST_TAKE_NEEDS_LAST: assert property (irq_take |-> $past(cpu.last_cycle)
		&& !$past(cpu.return_from_interrupt) && !$past(cpu.irq_reg_write))
		else $error("vectored outside instruction end");

	AST_GLOBAL_OFF: assert property (s_global_off |=> !irq_take)
		else $error("vectored with global enable off");

	AST_NO_PREEMPT_HIGH: assert property (irq_take |-> !$past(hi_busy))
		else $error("high routine preempted");

	AST_HIGH_FIRST: assert property (irq_take && |($past(sampled) & $past(priority_select))
		|-> taken_high)
		else $error("low request beat high request");

	AST_POLL_ORDER: assert property (irq_take |-> (($past(sampled)
		& (taken_high ? $past(priority_select) : ~$past(priority_select)))
		& ((12'h001 << taken_idx) - 12'h001)) == 12'h000)
		else $error("polling order violated");

	AST_VECTOR_MAP: assert property (irq_take |-> vector_addr == tlv_pkg::tlv_vec_of(taken_idx)
		&& vector_addr != tlv_pkg::VEC_NONE)
		else $error("wrong vector address");

	AST_TIMER0_CLEAR: assert property (irq_take && taken_idx == tlv_pkg::S_TMR0
		&& !$past(core_flag_set[tlv_pkg::C_TMR0]) && !$past(core_flag_wr[tlv_pkg::C_TMR0])
		|-> !core_flags[tlv_pkg::C_TMR0])
		else $error("timer0 flag not cleared on vectoring");

	AST_SERIAL_KEPT: assert property (irq_take && taken_idx == tlv_pkg::S_SER
		&& $past(core_flags[tlv_pkg::C_RXD]) && !$past(core_flag_wr[tlv_pkg::C_RXD])
		|-> core_flags[tlv_pkg::C_RXD])
		else $error("receive flag cleared by vectoring");

	AST_SET_WINS: assert property (|core_flag_set
		|=> (core_flags & $past(core_flag_set)) == $past(core_flag_set))
		else $error("hardware flag set lost");

	AST_RETURN_FROM_INTERRUPT_ENDS: assert property (s_return_from_interrupt_high |=> svc == tlv_pkg::SVC_IDLE
		##1 !svc_high_active || irq_take)
		else $error("return did not end high level");
endmodule : tlv_unit
`default_nettype wire

// ===== dv/tlv_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlv_cpu_model (
	input  wire logic          mclk,
	input  wire logic          nrst,
	input  wire logic          run,
	input  wire logic          slow,
	input  wire logic          wr_hold,
	input  wire logic          ret_go,
	input  wire logic          irq_take,
	input  wire logic [15:0]   vector_addr,
	output tlv_pkg::tlv_cpu_s  cpu
);
	logic        phase;
	logic        ret_pend;
	logic        fin;
	logic [15:0] pc;
	logic [15:0] stack [4];
	logic [1:0]  sp;

	// Slow mode gives two-cycle instructions so mid-instruction cycles occur
	assign fin = run & (~slow | phase);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cpu      <= '0;
			phase    <= 1'b0;
			ret_pend <= 1'b0;
			pc       <= 16'h0100;
			sp       <= 2'h0;
		end else begin
			phase               <= slow ? ~phase : 1'b0;
			cpu.cycle_valid     <= run;
			cpu.last_cycle      <= fin;
			cpu.irq_reg_write   <= run & wr_hold;
			cpu.return_from_interrupt            <= fin & ret_pend & ~cpu.return_from_interrupt;
			if (ret_go) begin
				ret_pend <= 1'b1;
			end else if (cpu.return_from_interrupt) begin
				ret_pend <= 1'b0;
			end
			// Stack depth of four covers the two levels with margin
			if (irq_take) begin
				stack[sp] <= pc;
				sp        <= sp + 2'h1;
				pc        <= vector_addr;
			end else if (cpu.return_from_interrupt && cpu.last_cycle) begin
				sp <= sp - 2'h1;
				pc <= stack[sp-2'h1];
			end else if (cpu.cycle_valid && cpu.last_cycle) begin
				pc <= pc + 16'h0001;
			end
		end
	end
endmodule : tlv_cpu_model
`default_nettype wire

// ===== dv/tlv_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tlv_unit_tb;
	logic              mclk, nrst, run, slow, wr_hold, ret_go, t2_pin;
	tlv_pkg::tlv_cpu_s cpu;
	logic [12:0]       en;
	logic [11:0]       prio;
	logic [6:0]        cfg;
	logic [3:0]        pins, tidx;
	logic [7:0]        cset, cwr, cdat, usb_ep, cflags;
	logic [4:0]        xwr, xdat, xflags;
	logic [2:0]        usb_ev;
	logic              irq_take, taken_high, svc_hi, svc_lo;
	logic [15:0]       vec;
	int                error_cnt, total_checks;
	// Source kind per slot: 0 pin flag write, 1 hw set, 2 fw set, 3 usb level
	int kind [12] = '{0, 1, 0, 1, 2, 1, 0, 0, 2, 2, 2, 3};
	int bitn [12] = '{0, 0, 1, 1, 3, 4, 2, 3, 5, 6, 7, 0};
	logic [15:0] vexp [12] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
		16'h0033, 16'h003b, 16'h0043, 16'h006b, 16'h0073, 16'h007b};

	tlv_unit i_tlv_unit (.mclk(mclk), .nrst(nrst), .cpu(cpu), .en(en), .priority_select(prio),
		.ext_cfg(cfg), .ext_pin(pins), .timer2_external_pin(t2_pin), .core_flag_set(cset),
		.core_flag_wr(cwr), .core_flag_data(cdat), .ext_flag_wr(xwr), .ext_flag_data(xdat),
		.usb_event_flags(usb_ev), .usb_endpoint_flags(usb_ep), .irq_take(irq_take),
		.vector_addr(vec), .taken_idx(tidx), .taken_high(taken_high), .svc_high_active(svc_hi),
		.svc_low_active(svc_lo), .core_flags(cflags), .ext_flags(xflags));
	tlv_cpu_model i_tlv_cpu_model (.mclk(mclk), .nrst(nrst), .run(run), .slow(slow), .wr_hold(wr_hold),
		.ret_go(ret_go), .irq_take(irq_take), .vector_addr(vec), .cpu(cpu));

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic fw(input logic [7:0] cm, input logic [7:0] cd, input logic [4:0] xm, input logic [4:0] xd);
		@(posedge mclk);
		cwr  <= cm;
		cdat <= cd;
		xwr  <= xm;
		xdat <= xd;
		@(posedge mclk);
		cwr <= '0;
		xwr <= '0;
	endtask : fw
	task automatic hw(input int b);
		@(posedge mclk);
		cset[b] <= 1'b1;
		@(posedge mclk);
		cset <= '0;
	endtask : hw
	task automatic take(input logic [15:0] v, input logic [3:0] i, input logic h);
		int n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (irq_take !== 1'b1 && n < 30);
		chk("take", irq_take, 1'b1);
		chk("vector", vec, v);
		chk("slot", tidx, i);
		chk("level", {svc_hi, taken_high}, {h, h});
	endtask : take
	task automatic no_take(input int n);
		repeat (n) begin
			@(posedge mclk);
			#1;
			chk("no take", irq_take, 1'b0);
		end
	endtask : no_take
	task automatic ret(input int w);
		@(posedge mclk);
		ret_go <= 1'b1;
		@(posedge mclk);
		ret_go <= 1'b0;
		repeat (w) @(posedge mclk);
	endtask : ret
	task automatic pin(input int p, input logic v, input logic e, input string nm);
		@(posedge mclk);
		if (p == 4) t2_pin <= v;
		else pins[p] <= v;
		repeat (6) @(posedge mclk);
		#1;
		chk(nm, xflags[p], e);
	endtask : pin
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		repeat (6000) @(posedge mclk);
		error_cnt++;
		$display("mismatch watchdog expected end seen hang");
		final_report();
	end
	initial begin
		{nrst, run, slow, wr_hold, ret_go, cset, cwr, cdat, xwr, xdat, usb_ev, usb_ep} = '0;
		{en, prio, error_cnt, total_checks} = '0;
		cfg    = 7'h7f;
		pins   = 4'h3;
		t2_pin = 1'b1;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		run <= 1'b1;
		repeat (4) @(posedge mclk);
		// Each slot alone: vector, flag cleared or kept on take, firmware clear
		for (int s = 0; s < 12; s++) begin
			en <= {1'b1, 12'h001 << s};
			case (kind[s])
				0: fw('0, '0, 5'h01 << bitn[s], 5'h1f);
				1: hw(bitn[s]);
				2: fw(8'h01 << bitn[s], 8'hff, '0, '0);
				default: @(posedge mclk) usb_ep <= 8'h80;
			endcase
			take(vexp[s], 4'(s), 1'b0);
			if (kind[s] == 0) chk("pin flag", xflags[bitn[s]], 1'b0);
			else if (kind[s] == 1) chk("hw flag", cflags[bitn[s]], bitn[s] == 4);
			else if (kind[s] == 2) chk("kept flag", cflags[bitn[s]], 1'b1);
			if (kind[s] == 3) @(posedge mclk) usb_ep <= '0;
			fw(kind[s] == 0 ? 8'h00 : 8'h01 << bitn[s], '0, '0, '0);
			ret(4);
			chk("idle", {svc_hi, svc_lo}, 2'b00);
		end
		$display("test vectors done");
		en <= 13'h0002;
		hw(0);
		no_take(10);
		en <= 13'h1002;
		take(16'h000b, 4'h1, 1'b0);
		ret(4);
		en     <= 13'h1800;
		usb_ev <= 3'h4;
		take(16'h007b, 4'hb, 1'b0);
		usb_ev <= '0;
		ret(4);
		$display("test global done");
		// Serial high, timer0 and ext1 low, all pending together
		en   <= 13'h0016;
		prio <= 12'h010;
		fw(8'h05, 8'h05, 5'h02, 5'h02);
		en <= 13'h1016;
		take(16'h0023, 4'h4, 1'b1);
		no_take(8);
		fw(8'h04, 8'h00, '0, '0);
		ret(0);
		take(16'h000b, 4'h1, 1'b0);
		ret(0);
		take(16'h0013, 4'h2, 1'b0);
		ret(4);
		prio <= '0;
		$display("test order done");
		slow    <= 1'b1;
		wr_hold <= 1'b1;
		en      <= 13'h1002;
		hw(0);
		no_take(10);
		wr_hold <= 1'b0;
		take(16'h000b, 4'h1, 1'b0);
		ret(6);
		slow <= 1'b0;
		$display("test blocking done");
		// Pin triggering with all requests masked
		en  <= '0;
		cfg <= 7'h4f;
		pin(0, 1'b0, 1'b1, "ext0 falling");
		pin(1, 1'b0, 1'b1, "ext1 low");
		pin(1, 1'b1, 1'b0, "ext1 released");
		pin(2, 1'b1, 1'b1, "ext2 high");
		pin(2, 1'b0, 1'b0, "ext2 low");
		pin(3, 1'b1, 1'b1, "ext3 rising");
		pin(4, 1'b0, 1'b1, "t2 falling");
		$display("test pins done");
		final_report();
	end
endmodule : tlv_unit_tb
`default_nettype wire
